/* ticr_pkg.sv */
package ticr_pkg;
	localparam logic [1:0] ADDR_CONTROL     = 2'h0;
	localparam logic [1:0] ADDR_IRQ_CONFIG  = 2'h1;
	localparam logic [1:0] ADDR_IRQ_STATUS  = 2'h2;
	localparam logic [1:0] ADDR_IRQ_MASK    = 2'h3;
	localparam int         BIT_T1_FLAG      = 7;
	localparam int         BIT_T1_RUN       = 6;
	localparam int         BIT_T0_FLAG      = 5;
	localparam int         BIT_T0_RUN       = 4;
	localparam int         BIT_X1_FLAG      = 3;
	localparam int         BIT_X1_TYPE      = 2;
	localparam int         BIT_X1_POLARITY  = 0;
	localparam logic [7:0] CONTROL_RESET    = 8'h00;
	localparam logic [7:0] CONFIG_RESET     = 8'h00;
	localparam logic       TYPE_LEVEL       = 1'h0;
	localparam logic       TYPE_EDGE        = 1'h1;
	localparam int         EVT_T0           = 0;
	localparam int         EVT_T1           = 1;
	localparam int         EVT_X1           = 2;
	localparam int         EVT_COUNT        = 3;
endpackage

/* ticr_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Flag controls passed from the register bank to the flag engine.
interface ticr_if;
	logic [2:0] set_evt;
	logic [2:0] sw_clr;
	logic [2:0] vec_clr;
	logic       level_mode;
	logic       level_active;
	logic [2:0] flags;
	modport bank (output set_evt, output sw_clr, output vec_clr, output level_mode, output level_active, input flags);
	modport eng  (input set_evt, input sw_clr, input vec_clr, input level_mode, input level_active, output flags);
endinterface
`default_nettype wire

/* ticr_flags.sv */
`timescale 1ns/1ps
`default_nettype none
// Flag engine, one flag per event source; sticky except X1 in level mode, which follows the pin.
module ticr_flags (
	// Clock and reset
	input wire logic  clk,
	input wire logic  rst_n,
	// Flag control
	ticr_if.eng       fl
);
	logic [2:0] flag;
	logic [2:0] next_flag;

	// Set wins over both clears so an overflow in the clear cycle survives.
	always_comb begin
		next_flag = flag;
		for (int i = 0; i < 3; i++) begin
			if (fl.set_evt[i]) begin
				next_flag[i] = 1'b1;
			end else if (fl.sw_clr[i] || fl.vec_clr[i]) begin
				next_flag[i] = 1'b0;
			end
		end
		if (fl.level_mode == ticr_pkg::TYPE_LEVEL) begin
			next_flag[ticr_pkg::EVT_X1] = fl.level_active;
		end
	end

	// Register the flags; all clear after reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 3'h0;
		end else begin
			flag <= next_flag;
		end
	end

	assign fl.flags = flag;
endmodule
`default_nettype wire

/* ticr_top.sv */
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Timer and external-interrupt control/status register bank.
module ticr_top (
	// Clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RST_N,
	// Register port
	input  wire logic [1:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	// Timer cores
	input  wire logic       T0_OVERFLOW,
	input  wire logic       T1_OVERFLOW,
	output logic            T0_RUN,
	output logic            T1_RUN,
	// External interrupt pin
	input  wire logic       EXT_IRQ_INPUT_A,
	// Vectoring acknowledges from the CPU
	input  wire logic       T0_VECTOR,
	input  wire logic       T1_VECTOR,
	input  wire logic       X1_VECTOR,
	// Requests to the CPU
	output logic            T0_FLAG,
	output logic            T1_FLAG,
	output logic            X1_FLAG,
	output logic            IRQ
);
	ticr_if fl ();

	logic       t0_run;
	logic       t1_run;
	logic       ext_irq1_type_sel;
	logic       ext_irq1_polarity;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [7:0] rdata;
	logic       pin_meta;
	logic       pin_sync;
	logic       pin_prev;
	logic       next_t0_run;
	logic       next_t1_run;
	logic       next_type_sel;
	logic       next_polarity;
	logic [2:0] next_irq_status;
	logic [2:0] next_irq_mask;
	logic [7:0] next_rdata;
	logic       pin_active;
	logic       pin_active_prev;
	logic       wr_ctl;
	logic [7:0] control_view;

	// Pin passes three flops; logic reads the second (pin_sync) and the third (pin_prev).
	// They reset to the inactive level of the reset polarity, so no false level or edge follows reset.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pin_meta <= ~ticr_pkg::CONFIG_RESET[ticr_pkg::BIT_X1_POLARITY];
			pin_sync <= ~ticr_pkg::CONFIG_RESET[ticr_pkg::BIT_X1_POLARITY];
			pin_prev <= ~ticr_pkg::CONFIG_RESET[ticr_pkg::BIT_X1_POLARITY];
		end else begin
			pin_meta <= EXT_IRQ_INPUT_A;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Polarity bit set means active high, clear means active low.
	assign pin_active      = ext_irq1_polarity ? pin_sync : ~pin_sync;
	assign pin_active_prev = ext_irq1_polarity ? pin_prev : ~pin_prev;
	assign wr_ctl          = WR && (ADDR == ticr_pkg::ADDR_CONTROL);

	// Flag engine requests.
	always_comb begin
		fl.set_evt[ticr_pkg::EVT_T0] = T0_OVERFLOW;
		fl.set_evt[ticr_pkg::EVT_T1] = T1_OVERFLOW;
		fl.set_evt[ticr_pkg::EVT_X1] = (ext_irq1_type_sel == ticr_pkg::TYPE_EDGE)
			&& pin_active && !pin_active_prev;
		fl.sw_clr[ticr_pkg::EVT_T0] = wr_ctl && !WDATA[ticr_pkg::BIT_T0_FLAG];
		fl.sw_clr[ticr_pkg::EVT_T1] = wr_ctl && !WDATA[ticr_pkg::BIT_T1_FLAG];
		fl.sw_clr[ticr_pkg::EVT_X1] = wr_ctl && !WDATA[ticr_pkg::BIT_X1_FLAG];
		fl.vec_clr[ticr_pkg::EVT_T0] = T0_VECTOR;
		fl.vec_clr[ticr_pkg::EVT_T1] = T1_VECTOR;
		fl.vec_clr[ticr_pkg::EVT_X1] = X1_VECTOR && (ext_irq1_type_sel == ticr_pkg::TYPE_EDGE);
		fl.level_mode   = ext_irq1_type_sel;
		fl.level_active = pin_active;
	end

	ticr_flags u_flags (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.fl    (fl)
	);

	// Assembled control register view as software reads it.
	always_comb begin
		control_view = ticr_pkg::CONTROL_RESET;
		control_view[ticr_pkg::BIT_T1_FLAG] = fl.flags[ticr_pkg::EVT_T1];
		control_view[ticr_pkg::BIT_T1_RUN]  = t1_run;
		control_view[ticr_pkg::BIT_T0_FLAG] = fl.flags[ticr_pkg::EVT_T0];
		control_view[ticr_pkg::BIT_T0_RUN]  = t0_run;
		control_view[ticr_pkg::BIT_X1_FLAG] = fl.flags[ticr_pkg::EVT_X1];
		control_view[ticr_pkg::BIT_X1_TYPE] = ext_irq1_type_sel;
	end

	// Register writes, read data and sticky status; a status read clears it, but a new event wins.
	always_comb begin
		next_t0_run     = t0_run;
		next_t1_run     = t1_run;
		next_type_sel   = ext_irq1_type_sel;
		next_polarity   = ext_irq1_polarity;
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		next_rdata      = 8'h00;
		if (wr_ctl) begin
			next_t1_run   = WDATA[ticr_pkg::BIT_T1_RUN];
			next_t0_run   = WDATA[ticr_pkg::BIT_T0_RUN];
			next_type_sel = WDATA[ticr_pkg::BIT_X1_TYPE];
		end
		if (WR && ADDR == ticr_pkg::ADDR_IRQ_CONFIG) begin
			next_polarity = WDATA[ticr_pkg::BIT_X1_POLARITY];
		end
		if (WR && ADDR == ticr_pkg::ADDR_IRQ_MASK) begin
			next_irq_mask = WDATA[2:0];
		end
		if (RD) begin
			unique case (ADDR)
				ticr_pkg::ADDR_CONTROL: begin
					next_rdata = control_view;
				end
				ticr_pkg::ADDR_IRQ_CONFIG: begin
					next_rdata = {7'h00, ext_irq1_polarity};
				end
				ticr_pkg::ADDR_IRQ_STATUS: begin
					next_rdata      = {5'h00, irq_status};
					next_irq_status = 3'h0;
				end
				ticr_pkg::ADDR_IRQ_MASK: begin
					next_rdata = {5'h00, irq_mask};
				end
			endcase
		end
		next_irq_status = next_irq_status | fl.set_evt;
	end

	// Register state; everything zero after reset.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			t0_run            <= 1'b0;
			t1_run            <= 1'b0;
			ext_irq1_type_sel <= ticr_pkg::TYPE_LEVEL;
			ext_irq1_polarity <= ticr_pkg::CONFIG_RESET[ticr_pkg::BIT_X1_POLARITY];
			irq_mask          <= 3'h0;
			irq_status        <= 3'h0;
			rdata             <= 8'h00;
		end else begin
			t0_run            <= next_t0_run;
			t1_run            <= next_t1_run;
			ext_irq1_type_sel <= next_type_sel;
			ext_irq1_polarity <= next_polarity;
			irq_mask          <= next_irq_mask;
			irq_status        <= next_irq_status;
			rdata             <= next_rdata;
		end
	end

	// Outputs straight from flops.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(next_irq_status & next_irq_mask);
		end
	end

	assign RDATA   = rdata;
	assign T0_RUN  = t0_run;
	assign T1_RUN  = t1_run;
	assign T0_FLAG = fl.flags[ticr_pkg::EVT_T0];
	assign T1_FLAG = fl.flags[ticr_pkg::EVT_T1];
	assign X1_FLAG = fl.flags[ticr_pkg::EVT_X1];
endmodule
`default_nettype wire

/* ticr_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the control register side of the bank at the top ports.
module ticr_chk (
	// All watched ports
	input wire logic       CLOCK, RST_N, WR, T0_OVERFLOW, T1_OVERFLOW, T0_VECTOR, T1_VECTOR,
	input wire logic       T0_RUN, T1_RUN, T0_FLAG, T1_FLAG,
	input wire logic [1:0] ADDR,
	input wire logic [7:0] WDATA
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// A write aimed at the control index.
	logic wc;
	assign wc = WR && (ADDR == 2'h0);
	t0_set_a: assert property (T0_OVERFLOW |=> T0_FLAG) else $error("t0 flag not set");
	t1_set_a: assert property (T1_OVERFLOW |=> T1_FLAG) else $error("t1 flag not set");
	t0_vec_a: assert property (T0_VECTOR && !T0_OVERFLOW |=> !T0_FLAG) else $error("t0 vector clear");
	t1_vec_a: assert property (T1_VECTOR && !T1_OVERFLOW |=> !T1_FLAG) else $error("t1 vector clear");
	t1_swclr_a: assert property (wc && !WDATA[7] && !T1_OVERFLOW |=> !T1_FLAG) else $error("t1 sw clear");
	t0_hold_a: assert property (T0_FLAG && !T0_VECTOR && !(wc && !WDATA[5]) |=> T0_FLAG) else $error("t0 lost");
	t0_run_a: assert property (wc && WDATA[4] |=> T0_RUN) else $error("t0 run not set");
	t1_run_a: assert property (wc && !WDATA[6] |=> !T1_RUN) else $error("t1 run not clear");
	run_keep_a: assert property (!wc |=> $stable(T0_RUN) && $stable(T1_RUN)) else $error("run moved");
endmodule
bind ticr_top ticr_chk u_chk (.*);
`default_nettype wire

/* ticr_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
// CPU vectoring model: pulses a vector for one cycle on a pending flag, at most every other cycle.
module ticr_cpu (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] go,
	input  wire logic [2:0] flags,
	output logic      [2:0] vec
);
	// The gap after a pulse keeps a still-set flag from being vectored in two consecutive cycles.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) vec <= 3'h0;
		else vec <= go & flags & ~vec;
	end
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        CLOCK, RST_N, WR, RD, T0_OVERFLOW, T1_OVERFLOW, EXT_IRQ_INPUT_A, T0_RUN, T1_RUN, IRQ, on;
	logic [1:0]  ADDR;
	logic [7:0]  WDATA, RDATA;
	logic [2:0]  go, vec, flg;
	logic [3:0]  ex;
	logic [31:0] r;
	int          n_mismatch, checks_done, cyc;
	ticr_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.T0_OVERFLOW(T0_OVERFLOW), .T1_OVERFLOW(T1_OVERFLOW), .T0_RUN(T0_RUN), .T1_RUN(T1_RUN),
		.EXT_IRQ_INPUT_A(EXT_IRQ_INPUT_A), .T0_VECTOR(vec[0]), .T1_VECTOR(vec[1]), .X1_VECTOR(vec[2]),
		.T0_FLAG(flg[0]), .T1_FLAG(flg[1]), .X1_FLAG(flg[2]), .IRQ(IRQ));
	ticr_cpu cpu (.clk(CLOCK), .rst_n(RST_N), .go(go), .flags(flg), .vec(vec));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Next {t1 flag, t1 run, t0 flag, t0 run}; an overflow outranks any clear.
	function automatic logic [3:0] nf(logic [3:0] e, logic w, logic [7:0] d, logic [1:0] o, logic [1:0] v);
		return {(e[3] & ~v[1] & ~(w & ~d[7])) | o[1], w ? d[6] : e[2], (e[1] & ~v[0] & ~(w & ~d[5])) | o[0],
			w ? d[4] : e[0]};
	endfunction
	task chk(string n, logic [7:0] e, logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wt(int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task wr(logic [1:0] a, logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task rd(logic [1:0] a, logic [7:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1 chk("rdata", e, RDATA);
	endtask
	task final_report();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	// Hang guard and reference model of the timer bits.
	always @(posedge CLOCK) begin
		cyc++;
		if (on) ex <= nf(ex, WR && ADDR == 2'h0, WDATA, {T1_OVERFLOW, T0_OVERFLOW}, vec[1:0]);
		if (cyc == 6000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		{RST_N, WR, RD, T0_OVERFLOW, T1_OVERFLOW, on, ADDR, WDATA, go, ex} = '0;
		EXT_IRQ_INPUT_A = 1'b1;
		r = 32'h1313030A;
		n_mismatch = 0;
		checks_done = 0;
		cyc = 0;
		repeat (12) @(posedge CLOCK);
		RST_N <= 1'b1;
		rd(2'h0, 8'h00);
		wr(2'h1, 8'h01);
		wt(5);
		chk("level_on", 8'h01, {7'h00, flg[2]});
		@(posedge CLOCK) EXT_IRQ_INPUT_A <= 1'b0;
		wt(5);
		chk("level_off", 8'h00, {7'h00, flg[2]});
		wr(2'h3, 8'h07);
		rd(2'h1, 8'h01);
		wr(2'h0, 8'h04);
		rd(2'h0, 8'h04);
		@(posedge CLOCK) EXT_IRQ_INPUT_A <= 1'b1;
		wt(6);
		chk("edge_set", 8'h03, {6'h00, IRQ, flg[2]});
		rd(2'h2, 8'h04);
		wt(2);
		chk("irq_drop", 8'h00, {7'h00, IRQ});
		@(posedge CLOCK) go <= 3'h4;
		wt(4);
		chk("edge_vec", 8'h00, {7'h00, flg[2]});
		@(posedge CLOCK) go <= 3'h0;
		// A second edge, then a software write of 0 to the flag bit must clear it.
		@(posedge CLOCK) EXT_IRQ_INPUT_A <= 1'b0;
		wt(4);
		@(posedge CLOCK) EXT_IRQ_INPUT_A <= 1'b1;
		wt(6);
		chk("edge_again", 8'h01, {7'h00, flg[2]});
		wr(2'h0, 8'h04);
		wt(1);
		chk("x1_swclr", 8'h00, {7'h00, flg[2]});
		on <= 1'b1;
		// Random traffic races overflows, vectors and clears in the same cycles.
		repeat (3000) begin
			@(posedge CLOCK);
			r = lfsr(r);
			WR <= &r[1:0];
			ADDR <= r[3:2];
			WDATA <= r[15:8];
			T0_OVERFLOW <= &r[5:4];
			T1_OVERFLOW <= &r[7:6];
			go <= {1'b0, r[17:16]};
			@(negedge CLOCK) chk("ctl", {4'h0, ex}, {4'h0, flg[1], T1_RUN, flg[0], T0_RUN});
		end
		final_report();
	end
endmodule
`default_nettype wire
